// ---- rtl/nbl_pkg.sv ----
// package for the neutral brake and limit override block
package nbl_pkg;
  localparam int STATUS_PERIOD_NS = 1000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [23:0] STATUS_PERIOD_CYC = 24'(STATUS_PERIOD_NS / CLK_PERIOD_NS);
  localparam int POL_HOLD_NS = 1000;
  localparam logic [7:0] POL_HOLD_CYC = 8'(POL_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [23:0] PERIOD_ZERO = 24'h000000;
  localparam logic [7:0] HOLD_ZERO = 8'h00;
  localparam logic [15:0] IDX_ZERO = 16'h0000;
  typedef enum logic [1:0] {neutral_no_override, neutral_brake, neutral_coast} nbl_neutral_t;
  typedef enum logic [1:0] {
    limit_switches_only_mode, limit_switches_and_soft_mode, limits_all_disabled_mode
  } nbl_limit_mode_t;
  typedef enum logic [1:0] {force_none, forced_on, forced_off} nbl_force_t;
  typedef enum {st_run, st_pause} nbl_state_e;
  // one frame of periodic status
  typedef struct packed {
    logic [15:0] duty;
    logic [2:0] ctrl_mode;
    logic brake;
    logic fwd_pin;
    logic rev_pin;
    logic [31:0] control_loop_error;
    logic [31:0] sensor_pos;
    logic [31:0] sensor_vel;
    logic [31:0] quad_pos;
    logic [31:0] quad_vel;
    logic [15:0] idx_rises;
    logic pin_a;
    logic pin_b;
    logic pin_idx;
    logic [31:0] ana_pos;
    logic [31:0] ana_vel;
    logic [9:0] adc_raw;
  } nbl_status_t;
  // self-test summary
  typedef struct packed {
    nbl_force_t fwd_force;
    nbl_force_t rev_force;
    logic brake;
  } nbl_selftest_t;
endpackage

// ---- rtl/nbl_override.sv ----
// neutral brake mode, limit override and periodic status logic
//
// How it works
// - indicator follows overridden brake or coast
// - override beats stored brake, store untouched
// - no override uses stored brake setting
// - forward and reverse enables overridden independently
// - three limit modes supported
// - self-test shows forced states and brake
// - polarity change briefly disables motor drive
// - separate polarity per limit input
// - status sent periodically, unsolicited
// - status sent in every control mode
// - status carries analog pos, vel, 10-bit adc
// - status carries duty, mode, brake, pins
// - status carries set point minus measurement
// - sensor from selected device, default quadrature
// - status carries quadrature values, index count, pins
// - stored settings change only on save or panel button
// - panel button toggles stored brake mode
`timescale 1ns/1ps
module nbl_override (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic neutral_wr,
  input wire nbl_pkg::nbl_neutral_t neutral_sel,
  input wire logic limit_ovr_wr,
  input wire logic limit_ovr_fwd_en,
  input wire logic limit_ovr_rev_en,
  input wire logic limit_mode_wr,
  input wire nbl_pkg::nbl_limit_mode_t limit_mode_sel,
  input wire logic pol_wr,
  input wire logic pol_fwd_nc,
  input wire logic pol_rev_nc,
  input wire logic save,
  input wire logic save_brake,
  input wire logic save_fwd_nc,
  input wire logic save_rev_nc,
  input wire logic cal_button,
  input wire logic soft_fwd_trip,
  input wire logic soft_rev_trip,
  input wire logic fwd_pin,
  input wire logic rev_pin,
  input wire logic [15:0] duty,
  input wire logic [2:0] ctrl_mode,
  input wire logic [31:0] set_point,
  input wire logic feedback_sel_valid,
  input wire logic feedback_sel_analog,
  input wire logic [31:0] quad_pos,
  input wire logic [31:0] quad_vel,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_idx,
  input wire logic [31:0] ana_pos,
  input wire logic [31:0] ana_vel,
  input wire logic [9:0] adc_raw,
  output logic brake_led,
  output logic brake_active,
  output logic drive_enable,
  output logic fwd_block,
  output logic rev_block,
  output logic stored_brake,
  output logic stored_fwd_nc,
  output logic stored_rev_nc,
  output nbl_pkg::nbl_selftest_t selftest,
  output logic status_valid,
  output nbl_pkg::nbl_status_t status
);
  typedef struct packed {
    nbl_pkg::nbl_neutral_t neutral;
    nbl_pkg::nbl_force_t fwd_force;
    nbl_pkg::nbl_force_t rev_force;
    nbl_pkg::nbl_limit_mode_t limit_mode;
    logic fwd_nc;
    logic rev_nc;
    logic st_brake;
    logic st_fwd_nc;
    logic st_rev_nc;
    logic button_q;
    logic idx_q;
    logic [15:0] idx_rises;
    logic [7:0] hold;
    logic [23:0] period;
    logic brake_led;
    logic brake_active;
    logic drive_enable;
    logic fwd_block;
    logic rev_block;
    nbl_pkg::nbl_selftest_t selftest;
    logic status_valid;
    nbl_pkg::nbl_status_t status;
  } nbl_state_t;

  nbl_state_t s;
  nbl_state_t next_s;
  logic rst_q1;
  logic rst_q2;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // next state of the whole block
  always_comb begin
    logic brake_now;
    logic fwd_en;
    logic rev_en;
    logic fwd_trip;
    logic rev_trip;
    logic [31:0] meas;
    brake_now = 1'b0;
    fwd_en = 1'b0;
    rev_en = 1'b0;
    fwd_trip = 1'b0;
    rev_trip = 1'b0;
    meas = 32'h00000000;
    next_s = s;
    // neutral override selection
    if (neutral_wr) begin
      next_s.neutral = neutral_sel;
    end
    // limit enable overrides, each side its own value
    if (limit_ovr_wr) begin
      next_s.fwd_force = limit_ovr_fwd_en ? nbl_pkg::forced_on : nbl_pkg::forced_off;
      next_s.rev_force = limit_ovr_rev_en ? nbl_pkg::forced_on : nbl_pkg::forced_off;
    end
    if (limit_mode_wr) begin
      next_s.limit_mode = limit_mode_sel;
    end
    // polarity change pauses drive only when a value differs
    if (pol_wr) begin
      next_s.fwd_nc = pol_fwd_nc;
      next_s.rev_nc = pol_rev_nc;
      if (pol_fwd_nc != s.fwd_nc || pol_rev_nc != s.rev_nc) begin
        next_s.hold = nbl_pkg::POL_HOLD_CYC;
      end
    end
    // stored settings: save action, or panel button edge
    next_s.button_q = cal_button;
    if (save) begin
      next_s.st_brake = save_brake;
      next_s.st_fwd_nc = save_fwd_nc;
      next_s.st_rev_nc = save_rev_nc;
      next_s.fwd_nc = save_fwd_nc;
      next_s.rev_nc = save_rev_nc;
      if (save_brake != s.st_brake || save_fwd_nc != s.fwd_nc || save_rev_nc != s.rev_nc) begin
        next_s.hold = nbl_pkg::POL_HOLD_CYC;
      end
    end else if (cal_button && !s.button_q) begin
      next_s.st_brake = !s.st_brake;
    end
    if (s.hold != nbl_pkg::HOLD_ZERO && !(pol_wr || save)) begin
      next_s.hold = s.hold - 8'h01;
    end
    // active neutral behaviour
    case (s.neutral)
      nbl_pkg::neutral_brake: brake_now = 1'b1;
      nbl_pkg::neutral_coast: brake_now = 1'b0;
      default: brake_now = s.st_brake;
    endcase
    next_s.brake_active = brake_now;
    next_s.brake_led = brake_now;
    // limit enables from mode and overrides
    fwd_en = s.limit_mode != nbl_pkg::limits_all_disabled_mode;
    rev_en = fwd_en;
    if (s.fwd_force != nbl_pkg::force_none) begin
      fwd_en = s.fwd_force == nbl_pkg::forced_on;
    end
    if (s.rev_force != nbl_pkg::force_none) begin
      rev_en = s.rev_force == nbl_pkg::forced_on;
    end
    // disabled mode silences both inputs, forced or not
    if (s.limit_mode == nbl_pkg::limits_all_disabled_mode) begin
      fwd_en = 1'b0;
      rev_en = 1'b0;
    end
    // pin closed for open type reads high, tripped follows polarity
    fwd_trip = fwd_en && (fwd_pin ^ s.fwd_nc);
    rev_trip = rev_en && (rev_pin ^ s.rev_nc);
    if (s.limit_mode == nbl_pkg::limit_switches_and_soft_mode) begin
      fwd_trip = fwd_trip || soft_fwd_trip;
      rev_trip = rev_trip || soft_rev_trip;
    end
    next_s.fwd_block = fwd_trip;
    next_s.rev_block = rev_trip;
    next_s.drive_enable = next_s.hold == nbl_pkg::HOLD_ZERO;
    // self-test summary
    next_s.selftest.fwd_force = s.fwd_force;
    next_s.selftest.rev_force = s.rev_force;
    next_s.selftest.brake = brake_now;
    // index rising edge count
    next_s.idx_q = pin_idx;
    if (pin_idx && !s.idx_q) begin
      next_s.idx_rises = s.idx_rises + 16'h0001;
    end
    // measured value from selected feedback, quadrature by default
    meas = (feedback_sel_valid && feedback_sel_analog) ? ana_pos : quad_pos;
    // periodic unsolicited status, independent of control mode
    next_s.status_valid = 1'b0;
    if (s.period == nbl_pkg::PERIOD_ZERO) begin
      next_s.period = nbl_pkg::STATUS_PERIOD_CYC - 24'h000001;
      next_s.status_valid = 1'b1;
      next_s.status.duty = duty;
      next_s.status.ctrl_mode = ctrl_mode;
      next_s.status.brake = brake_now;
      next_s.status.fwd_pin = fwd_pin;
      next_s.status.rev_pin = rev_pin;
      next_s.status.control_loop_error = set_point - meas;
      next_s.status.sensor_pos = meas;
      next_s.status.sensor_vel =
        (feedback_sel_valid && feedback_sel_analog) ? ana_vel : quad_vel;
      next_s.status.quad_pos = quad_pos;
      next_s.status.quad_vel = quad_vel;
      next_s.status.idx_rises = s.idx_rises;
      next_s.status.pin_a = pin_a;
      next_s.status.pin_b = pin_b;
      next_s.status.pin_idx = pin_idx;
      next_s.status.ana_pos = ana_pos;
      next_s.status.ana_vel = ana_vel;
      next_s.status.adc_raw = adc_raw;
    end else begin
      next_s.period = s.period - 24'h000001;
    end
  end

  // state register; reset drops overrides, stored values default
  always_ff @(posedge ref_clk or negedge rst_q2) begin
    if (!rst_q2) begin
      s <= '0;
      s.neutral <= nbl_pkg::neutral_no_override;
      s.fwd_force <= nbl_pkg::force_none;
      s.rev_force <= nbl_pkg::force_none;
      s.limit_mode <= nbl_pkg::limit_switches_only_mode;
      s.st_brake <= 1'b1;
      s.brake_led <= 1'b1;
      s.brake_active <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign brake_led = s.brake_led;
  assign brake_active = s.brake_active;
  assign drive_enable = s.drive_enable;
  assign fwd_block = s.fwd_block;
  assign rev_block = s.rev_block;
  assign stored_brake = s.st_brake;
  assign stored_fwd_nc = s.st_fwd_nc;
  assign stored_rev_nc = s.st_rev_nc;
  assign selftest = s.selftest;
  assign status_valid = s.status_valid;
  assign status = s.status;
endmodule

// ---- bench/nbl_override_asserts.sv ----
// assertion checker for the neutral brake and limit override block
`timescale 1ns/1ps
module nbl_override_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic neutral_wr,
  input wire nbl_pkg::nbl_neutral_t neutral_sel,
  input wire logic limit_ovr_wr,
  input wire logic limit_ovr_fwd_en,
  input wire logic limit_ovr_rev_en,
  input wire logic save,
  input wire logic cal_button,
  input wire logic brake_led,
  input wire logic brake_active,
  input wire logic drive_enable,
  input wire logic stored_brake,
  input wire nbl_pkg::nbl_selftest_t selftest,
  input wire logic status_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // indicator and neutral selection
  chk_led_brake_eq: assert property (brake_led == brake_active)
    else $error("indicator differs from brake state");
  chk_ovr_brake_on: assert property (neutral_wr && neutral_sel == nbl_pkg::neutral_brake
    ##1 !neutral_wr |=> brake_active) else $error("brake override not applied");
  chk_ovr_coast_on: assert property (neutral_wr && neutral_sel == nbl_pkg::neutral_coast
    ##1 !neutral_wr |=> !brake_led) else $error("coast override not shown");
  chk_no_ovr_stored: assert property (neutral_wr
    && neutral_sel == nbl_pkg::neutral_no_override ##1 !(neutral_wr || save || cal_button)
    |=> brake_active == stored_brake) else $error("stored brake not used");
  // self-test report of forced limits and brake
  chk_fwd_force_rpt: assert property (limit_ovr_wr ##1 !limit_ovr_wr |=>
    selftest.fwd_force == ($past(limit_ovr_fwd_en, 2) ? nbl_pkg::forced_on : nbl_pkg::forced_off))
    else $error("forward force report wrong");
  chk_rev_force_rpt: assert property (limit_ovr_wr ##1 !limit_ovr_wr |=>
    selftest.rev_force == ($past(limit_ovr_rev_en, 2) ? nbl_pkg::forced_on : nbl_pkg::forced_off))
    else $error("reverse force report wrong");
  chk_brake_rpt: assert property (neutral_wr ##1 !neutral_wr |=> selftest.brake == brake_active)
    else $error("brake report wrong");
  // pause length and status spacing
  chk_pause_min: assert property ($fell(drive_enable) |=> !drive_enable [*8])
    else $error("drive pause too short");
  chk_status_gap: assert property (status_valid |=> !status_valid [*8])
    else $error("status pulses too close");
endmodule
bind nbl_override nbl_override_asserts u_chk (.*);

// ---- bench/nbl_ctrl_model.sv ----
// robot controller model issuing override, limit mode and polarity commands
`timescale 1ns/1ps
module nbl_ctrl_model (
  input wire logic ref_clk,
  output logic neutral_wr,
  output nbl_pkg::nbl_neutral_t neutral_sel,
  output logic limit_ovr_wr,
  output logic limit_ovr_fwd_en,
  output logic limit_ovr_rev_en,
  output logic limit_mode_wr,
  output nbl_pkg::nbl_limit_mode_t limit_mode_sel,
  output logic pol_wr,
  output logic pol_fwd_nc,
  output logic pol_rev_nc
);
  // idle command lines
  initial begin
    {neutral_wr, limit_ovr_wr, limit_ovr_fwd_en, limit_ovr_rev_en} = 4'h0;
    {limit_mode_wr, pol_wr, pol_fwd_nc, pol_rev_nc} = 4'h0;
    neutral_sel = nbl_pkg::neutral_no_override;
    limit_mode_sel = nbl_pkg::limit_switches_only_mode;
  end
  // each command is a one-cycle strobe with its values
  task automatic put_neutral(input nbl_pkg::nbl_neutral_t s);
    @(posedge ref_clk) {neutral_wr, neutral_sel} <= {1'b1, s};
    @(posedge ref_clk) neutral_wr <= 1'b0;
  endtask
  task automatic put_limits(input logic f, input logic r);
    @(posedge ref_clk) {limit_ovr_wr, limit_ovr_fwd_en, limit_ovr_rev_en} <= {1'b1, f, r};
    @(posedge ref_clk) limit_ovr_wr <= 1'b0;
  endtask
  task automatic put_mode(input nbl_pkg::nbl_limit_mode_t m);
    @(posedge ref_clk) {limit_mode_wr, limit_mode_sel} <= {1'b1, m};
    @(posedge ref_clk) limit_mode_wr <= 1'b0;
  endtask
  task automatic put_pol(input logic f, input logic r);
    @(posedge ref_clk) {pol_wr, pol_fwd_nc, pol_rev_nc} <= {1'b1, f, r};
    @(posedge ref_clk) pol_wr <= 1'b0;
  endtask
endmodule

// ---- bench/nbl_override_bench.sv ----
// testbench for the neutral brake and limit override block
`timescale 1ns/1ps
module nbl_override_bench;
  logic ref_clk, resetn, save, save_brake, cal_button, soft_rev_trip, fwd_pin, rev_pin;
  logic neutral_wr, limit_ovr_wr, limit_ovr_fwd_en, limit_ovr_rev_en, limit_mode_wr;
  logic pol_wr, pol_fwd_nc, pol_rev_nc, brake_led, brake_active, drive_enable;
  logic fwd_block, rev_block, stored_brake, stored_fwd_nc, stored_rev_nc, status_valid;
  logic save_fwd_nc, save_rev_nc, soft_fwd_trip, feedback_sel_valid, feedback_sel_analog;
  logic pin_a, pin_b, pin_idx;
  logic [31:0] quad_pos, ana_pos;
  logic [9:0] adc_raw;
  nbl_pkg::nbl_neutral_t neutral_sel;
  nbl_pkg::nbl_limit_mode_t limit_mode_sel;
  nbl_pkg::nbl_selftest_t selftest;
  nbl_pkg::nbl_status_t status, cap;
  logic got = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int i;
  nbl_ctrl_model ctl (.*);
  nbl_override DUT (.*, .duty(16'h1234), .ctrl_mode(3'h2), .set_point(32'h00000100),
    .quad_vel(32'h00000007), .ana_vel(32'h00000000));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // keep the first status frame
  always @(posedge ref_clk) if (status_valid === 1'b1 && !got) begin
    cap <= status;
    got <= 1'b1;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
  initial begin
    {resetn, save, save_brake, cal_button, soft_rev_trip, fwd_pin, rev_pin} = 7'h00;
    {save_fwd_nc, save_rev_nc, soft_fwd_trip, feedback_sel_valid, feedback_sel_analog} = 5'h00;
    {pin_a, pin_b, pin_idx} = 3'h5;
    quad_pos = 32'h00000040;
    ana_pos = 32'h000003FF;
    adc_raw = 10'h3FF;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(4);
    chk("drive", drive_enable, 1);
    chk("selftest", selftest, {nbl_pkg::force_none, nbl_pkg::force_none, 1'b1});
    @(posedge ref_clk) cal_button <= 1'b1;
    cyc(6);
    chk("stored", stored_brake, 0);
    @(posedge ref_clk) cal_button <= 1'b0;
    ctl.put_neutral(nbl_pkg::neutral_brake);
    cyc(2);
    chk("led", brake_led, 1);
    chk("stored", stored_brake, 0);
    chk("st brake", selftest.brake, 1);
    ctl.put_neutral(nbl_pkg::neutral_coast);
    cyc(2);
    chk("led", brake_led, 0);
    ctl.put_neutral(nbl_pkg::neutral_brake);
    ctl.put_neutral(nbl_pkg::neutral_no_override);
    cyc(2);
    chk("active", brake_active, 0);
    @(posedge ref_clk) {save, save_brake} <= 2'h3;
    @(posedge ref_clk) save <= 1'b0;
    cyc(2);
    chk("saved", stored_brake, 1);
    chk("active", brake_active, 1);
    chk("save pause", drive_enable, 0);
    chk("st fwd nc", stored_fwd_nc, 0);
    chk("st rev nc", stored_rev_nc, 0);
    cyc(int'(nbl_pkg::POL_HOLD_CYC));
    chk("resume", drive_enable, 1);
    ctl.put_limits(1'b1, 1'b0);
    cyc(2);
    chk("fwd force", selftest.fwd_force, nbl_pkg::forced_on);
    chk("rev force", selftest.rev_force, nbl_pkg::forced_off);
    ctl.put_limits(1'b1, 1'b1);
    @(posedge ref_clk) fwd_pin <= 1'b1;
    cyc(3);
    chk("fwd blk", fwd_block, 1);
    chk("rev blk", rev_block, 0);
    ctl.put_pol(1'b1, 1'b0);
    cyc(3);
    chk("pause", drive_enable, 0);
    i = 0;
    while (drive_enable !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    chk("hold", i > 150 && i < 400, 1);
    chk("fwd nc", fwd_block, 0);
    chk("store nc", stored_fwd_nc, 0);
    ctl.put_pol(1'b1, 1'b0);
    cyc(3);
    chk("no pause", drive_enable, 1);
    ctl.put_limits(1'b0, 1'b1);
    @(posedge ref_clk) {fwd_pin, rev_pin} <= 2'h1;
    cyc(3);
    chk("fwd off", fwd_block, 0);
    chk("rev no", rev_block, 1);
    ctl.put_mode(nbl_pkg::limits_all_disabled_mode);
    cyc(3);
    chk("all off", rev_block, 0);
    ctl.put_mode(nbl_pkg::limit_switches_and_soft_mode);
    @(posedge ref_clk) {rev_pin, soft_rev_trip} <= 2'h1;
    cyc(3);
    chk("soft", rev_block, 1);
    ctl.put_mode(nbl_pkg::limit_switches_only_mode);
    cyc(3);
    chk("sw only", rev_block, 0);
    chk("st seen", got, 1);
    chk("st duty", cap.duty, 16'h1234);
    chk("st mode", cap.ctrl_mode, 3'h2);
    chk("st adc", cap.adc_raw, 10'h3FF);
    chk("st err", cap.control_loop_error, 32'h000000C0);
    chk("st sens", cap.sensor_pos, 32'h00000040);
    chk("st pins", {cap.pin_a, cap.pin_b, cap.pin_idx}, 3'h5);
    chk("st svel", cap.sensor_vel, 32'h00000007);
    chk("st qpos", cap.quad_pos, 32'h00000040);
    chk("st idx", cap.idx_rises, 16'h0000);
    chk("st apos", cap.ana_pos, 32'h000003FF);
    chk("st brake", cap.brake, 1);
    test_done;
  end
endmodule
